/* design/dlmc_line_drv.sv */
// pin stage: two-flop synchronisers and registered open-drain enables
// assumes the pins are asynchronous and pulled up outside the chip
`timescale 1ns/1ns
`default_nettype none
module dlmc_line_drv
(
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // lines toward the control logic
    dlmc_line_if.drv  lines
);
    genvar g;
    generate
        for (g = 0; g < dlmc_pkg::NUM_LINES; g++)
        begin : g_line
            logic meta_r;
            logic sync_r;
            logic oe_r;
            logic meta_nxt;
            logic sync_nxt;
            logic oe_nxt;
            // first stage only feeds the second, nothing else looks at it
            always_comb
            begin
                meta_nxt = lines.raw[g];
                sync_nxt = meta_r;
                oe_nxt   = lines.drive_low[g];
            end
            // pins idle high, so the synchronisers reset to one
            always_ff @(posedge ref_clk_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    meta_r <= 1'b1;
                    sync_r <= 1'b1;
                    oe_r   <= 1'b0;
                end
                else
                begin
                    meta_r <= meta_nxt;
                    sync_r <= sync_nxt;
                    oe_r   <= oe_nxt;
                end
            end
            assign lines.level[g] = sync_r;
            assign lines.oe[g]    = oe_r;
        end
    endgenerate
endmodule // dlmc_line_drv
`default_nettype wire

/* design/dlmc_line_if.sv */
// carrier between the control logic and the downstream pin stage
// assumes both ends run on the same clock
`timescale 1ns/1ns
`default_nettype none
interface dlmc_line_if;
    logic [1:0] raw;        // pin levels as they arrive
    logic [1:0] level;      // synchronised pin levels
    logic [1:0] drive_low;  // request to pull a line low
    logic [1:0] oe;         // registered output enables
    modport drv (input raw, input drive_low, output level, output oe);
    modport ctl (output raw, output drive_low, input level, input oe);
endinterface
`default_nettype wire

/* design/dlmc_pkg.sv */
// constants for the downstream line manual control block
// assumes an upstream register port that hands over a decoded pointer
package dlmc_pkg;
    // register selection and reset value
    localparam int unsigned PTR_W           = 3;
    localparam logic [2:0]  STATUS_PTR      = 3'h2;
    localparam logic [7:0]  STATUS_RST      = 8'h00;
    localparam logic [7:0]  RDATA_RST       = 8'h00;
    localparam logic [7:0]  UNMAPPED_RDATA  = 8'h00;
    // field positions inside the status register
    localparam int unsigned SDA_BIT         = 7;
    localparam int unsigned SCL_BIT         = 6;
    localparam int unsigned LOW_W           = 6;
    // line indices on the pin carrier
    localparam int unsigned NUM_LINES       = 2;
    localparam int unsigned LINE_SDA        = 0;
    localparam int unsigned LINE_SCL        = 1;
    // manual bit value after reset
    localparam logic        MAN_RST         = 1'b0;
endpackage

/* design/dlmc_top.sv */
// manual control of the downstream data and clock lines
// assumes a register port already decoded from the upstream serial slave,
// and ownership and connect bits supplied by the arbiter on the same clock
`timescale 1ns/1ns
`default_nettype none
// Contract
// - status at pointer 010b, resets to 00h
// - bit 7 reads downstream data level
// - writing 0 drives data line low
// - writing 1 releases data line
// - data bit acts only unconnected and granted
// - bit 6 reads downstream clock level
// - writing 0 drives clock line low
// - writing 1 releases clock line
// - clock bit acts only unconnected and granted
// - switch closes only when connect and owned
// - grant reads one only for owner
module dlmc_top
(
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    // register port from the upstream slave
    input  wire logic [2:0] reg_ptr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_rd_i,
    input  wire logic [5:0] other_status_i,
    output logic      [7:0] reg_rdata_o,
    // ownership from the arbiter
    input  wire logic       lock_grant_i,
    input  wire logic       bus_connect_i,
    output logic            lock_grant_o,
    output logic            switch_close_o,
    output logic            manual_active_o,
    // downstream open-drain lines
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe_o
);
    dlmc_line_if lines ();

    logic       man_sda_r;
    logic       man_scl_r;
    logic       man_sda_nxt;
    logic       man_scl_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       manual_r;
    logic       manual_nxt;
    logic       switch_r;
    logic       switch_nxt;
    logic       grant_r;
    logic       grant_nxt;
    logic       manual_now;
    logic       status_sel;

    // pins into the synchronising stage
    assign lines.raw[dlmc_pkg::LINE_SDA] = sda_i;
    assign lines.raw[dlmc_pkg::LINE_SCL] = scl_i;

    dlmc_line_drv u_drv
    (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .lines     (lines)
    );

    assign status_sel = (reg_ptr_i == dlmc_pkg::STATUS_PTR);

    // manual only while open and owned
    // same gate for the clock line
    assign manual_now = lock_grant_i & ~bus_connect_i;

    // drive data low on a stored zero
    // stored one releases the data line
    // no drive request outside manual mode
    assign lines.drive_low[dlmc_pkg::LINE_SDA] = manual_now & ~man_sda_r;
    // drive clock low on a stored zero
    // stored one releases the clock line
    assign lines.drive_low[dlmc_pkg::LINE_SCL] = manual_now & ~man_scl_r;

    // manual bits: stored on any status write, even outside manual mode,
    // so software can preload a release before taking the lines over
    always_comb
    begin
        man_sda_nxt = man_sda_r;
        man_scl_nxt = man_scl_r;
        if (reg_wr_i && status_sel)
        begin
            man_sda_nxt = reg_wdata_i[dlmc_pkg::SDA_BIT];
            man_scl_nxt = reg_wdata_i[dlmc_pkg::SCL_BIT];
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            man_sda_r <= dlmc_pkg::MAN_RST;
            man_scl_r <= dlmc_pkg::MAN_RST;
        end
        else
        begin
            man_sda_r <= man_sda_nxt;
            man_scl_r <= man_scl_nxt;
        end
    end

    // read data: captured on the edge that samples the strobe, held until next read
    always_comb
    begin
        rdata_nxt = rdata_r;
        if (reg_rd_i)
        begin
            if (status_sel)
            begin
                rdata_nxt = {lines.level[dlmc_pkg::LINE_SDA],
                             lines.level[dlmc_pkg::LINE_SCL],
                             other_status_i};
            end
            else
            begin
                rdata_nxt = dlmc_pkg::UNMAPPED_RDATA;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            rdata_r <= dlmc_pkg::RDATA_RST;
        else
            rdata_r <= rdata_nxt;
    end

    // ownership derived outputs, registered to keep the pins glitch free
    always_comb
    begin
        switch_nxt = bus_connect_i & lock_grant_i;
        // grant shown only to the owner
        grant_nxt  = lock_grant_i;
        manual_nxt = manual_now;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            switch_r <= 1'b0;
            grant_r  <= 1'b0;
            manual_r <= 1'b0;
        end
        else
        begin
            switch_r <= switch_nxt;
            grant_r  <= grant_nxt;
            manual_r <= manual_nxt;
        end
    end

    // output pins: open drain, the data level is always low
    assign reg_rdata_o     = rdata_r;
    assign switch_close_o  = switch_r;
    assign lock_grant_o    = grant_r;
    assign manual_active_o = manual_r;
    assign sda_o           = 1'b0;
    assign scl_o           = 1'b0;
    assign sda_oe_o        = lines.oe[dlmc_pkg::LINE_SDA];
    assign scl_oe_o        = lines.oe[dlmc_pkg::LINE_SCL];

    // checks on the block's own outputs and on its stored manual bits
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    data_read_a : assert property (
        reg_rd_i && status_sel |=>
            reg_rdata_o[dlmc_pkg::SDA_BIT] ==
            $past(lines.level[dlmc_pkg::LINE_SDA]))
        else $error("status bit 7 does not show the data line");

    clock_read_a : assert property (
        reg_rd_i && status_sel |=>
            reg_rdata_o[dlmc_pkg::SCL_BIT] ==
            $past(lines.level[dlmc_pkg::LINE_SCL]))
        else $error("status bit 6 does not show the clock line");

    data_low_a : assert property (
        reg_wr_i && status_sel && !reg_wdata_i[dlmc_pkg::SDA_BIT]
            ##1 manual_now [*2] |-> sda_oe_o)
        else $error("data line not driven low after writing zero");

    data_release_a : assert property (
        reg_wr_i && status_sel && reg_wdata_i[dlmc_pkg::SDA_BIT]
            |-> ##2 !sda_oe_o)
        else $error("data line still driven after writing one");

    clock_low_a : assert property (
        reg_wr_i && status_sel && !reg_wdata_i[dlmc_pkg::SCL_BIT]
            ##1 manual_now [*2] |-> scl_oe_o)
        else $error("clock line not driven low after writing zero");

    clock_release_a : assert property (
        reg_wr_i && status_sel && reg_wdata_i[dlmc_pkg::SCL_BIT]
            |-> ##2 !scl_oe_o)
        else $error("clock line still driven after writing one");

    manual_gate_a : assert property (
        !manual_now |=> !sda_oe_o && !scl_oe_o)
        else $error("line driven outside manual mode");

    manual_flag_a : assert property (
        (sda_oe_o || scl_oe_o) |-> manual_active_o)
        else $error("line driven without manual flag");

    // first edge after reset is skipped: the flops were still held there
    switch_gate_a : assert property (
        !$past(rst_i) |->
            switch_close_o == ($past(lock_grant_i) && $past(bus_connect_i)))
        else $error("switch state does not follow ownership and connect");

    grant_show_a : assert property (
        !$past(rst_i) |-> lock_grant_o == $past(lock_grant_i))
        else $error("grant not shown to the owner");

    status_wr_a : assert property (
        reg_wr_i && !status_sel |=> $stable(man_sda_r) && $stable(man_scl_r))
        else $error("manual bits changed by another pointer");
endmodule // dlmc_top
`default_nettype wire

/* tb/dlmc_bus_model.sv */
// downstream wire pair with pull-ups and a second device on it
// assumes enables from the block are high while it pulls a line low
`timescale 1ns/1ns
`default_nettype none
module dlmc_bus_model
(
    // pull-down requests
    input  wire logic       sda_oe_i,
    input  wire logic       scl_oe_i,
    input  wire logic [1:0] ext_low_i,
    // resolved wire levels
    output logic            sda_o,
    output logic            scl_o
);
    assign sda_o = ~(sda_oe_i | ext_low_i[0]);
    assign scl_o = ~(scl_oe_i | ext_low_i[1]);
endmodule // dlmc_bus_model
`default_nettype wire

/* tb/dlmc_top_test.sv */
// self-checking bench for the downstream line manual control block
// assumes the bus model stands for the pulled-up downstream wires
`timescale 1ns/1ns
`default_nettype none
module dlmc_top_test;
    logic        ref_clk_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic [2:0]  ptr       = 3'h0;
    logic        wr        = 1'b0;
    logic        rd        = 1'b0;
    logic        rd_d      = 1'b0;
    logic [7:0]  wdata     = 8'h00;
    logic [5:0]  oth       = 6'h00;
    logic        grant     = 1'b0;
    logic        conn      = 1'b0;
    logic        md;
    logic [1:0]  ext_low   = 2'h0;
    logic [7:0]  rdata;
    logic        gr_o, sw_o, man_o, sda, scl, sda_oe, scl_oe;
    logic        sda_dv, scl_dv;
    logic [31:0] seed      = 32'h5ab794d2;
    logic [7:0]  exp_q[$];
    int          err_total = 0;
    int          n_checks  = 0;

    dlmc_top uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_ptr_i(ptr),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
        .other_status_i(oth), .reg_rdata_o(rdata), .lock_grant_i(grant),
        .bus_connect_i(conn), .lock_grant_o(gr_o), .switch_close_o(sw_o),
        .manual_active_o(man_o), .sda_i(sda), .sda_o(sda_dv),
        .sda_oe_o(sda_oe), .scl_i(scl), .scl_o(scl_dv), .scl_oe_o(scl_oe));
    dlmc_bus_model bus (.sda_oe_i(sda_oe), .scl_oe_i(scl_oe),
        .ext_low_i(ext_low), .sda_o(sda), .scl_o(scl));

    // free-running clock
    initial
    begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string nm);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done();
        if (err_total == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // read strobe; the expected byte is noted for the monitor
    task automatic rd_reg(input logic [2:0] p, input logic [1:0] lv);
        @(posedge ref_clk_i);
        ptr <= p;
        rd  <= 1'b1;
        exp_q.push_back((p == 3'h2) ? {lv, oth} : 8'h00);
        @(posedge ref_clk_i);
        rd  <= 1'b0;
    endtask

    // write strobe, then time for the enables and synchronisers to settle
    task automatic wr_reg(input logic [2:0] p, input logic [1:0] d);
        @(posedge ref_clk_i);
        seed = lfsr(seed);
        ptr   <= p;
        wr    <= 1'b1;
        wdata <= {d, seed[5:0]};
        oth   <= seed[13:8];
        @(posedge ref_clk_i);
        wr    <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
    endtask

    // monitor: read data stands one cycle after the read edge
    always @(posedge ref_clk_i)
    begin
        if (rd_d)
            check(rdata, exp_q.pop_front(), "read data");
        rd_d <= rd;
    end

    // every grant and connect pairing against every pair of manual bits
    initial
    begin
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        #1;
        check(rdata, 8'h00, "reset rdata");
        for (int i = 0; i < 16; i++)
        begin
            @(posedge ref_clk_i);
            grant   <= i[3];
            conn    <= i[2];
            ext_low <= seed[17:16] & {2{i[0]}};
            wr_reg(3'h2, i[1:0]);
            // a write elsewhere must leave the manual bits alone
            wr_reg(3'h3, ~i[1:0]);
            md = grant & ~conn;
            check({4'h0, sda_dv, scl_dv, sda_oe, scl_oe},
                  {6'h0, md & ~i[1], md & ~i[0]},
                  "enables");
            check({5'h0, gr_o, sw_o, man_o},
                  {5'h0, grant, grant & conn, md},
                  "ownership");
            rd_reg(3'h2, {~(md & ~i[1]) & ~ext_low[0],
                          ~(md & ~i[0]) & ~ext_low[1]});
            rd_reg(3'h6, 2'h0);
        end
        // mid-run reset with manual mode held: stored zeros pull both low
        @(posedge ref_clk_i);
        grant <= 1'b1;
        conn  <= 1'b0;
        rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        #1;
        check(rdata, 8'h00, "rerun rdata");
        repeat (3) @(posedge ref_clk_i);
        check({6'h0, sda_oe, scl_oe}, 8'h03, "reset enables");
        rd_reg(3'h2, 2'h0);
        repeat (3) @(posedge ref_clk_i);
        test_done();
    end

    // watchdog well beyond the few hundred cycles the run needs
    initial
    begin
        #50000;
        err_total++;
        test_done();
    end
endmodule // dlmc_top_test
`default_nettype wire
